// File: dv/sps_partner.sv
// Far side of the port: external power switch, partner hub and pull-ups.
// Assumes the bench raises its fault requests just after a clock edge.
`timescale 1ns/1ps
module sps_partner (
   input wire logic port_power,
   input wire logic fault_req,
   input wire logic hub_ocs_req,
   input wire logic [3:0] od_o,
   input wire logic [3:0] od_oe,
   output logic ppc_fault_n,
   output logic overcurrent_sense_n,
   output logic [3:0] od_pin
);
   // A switch can only report overcurrent while it is supplying the port
   assign ppc_fault_n = ~(fault_req & port_power);
   // Weak pull-up on the hub report line
   assign overcurrent_sense_n = ~hub_ocs_req;
   // Open-drain lines float high unless pulled low
   assign od_pin = (od_oe & od_o) | ~od_oe;
endmodule

// File: dv/sps_top_tb.sv
// Self-checking bench for the standalone port signalling block.
// Assumes the partner model resolves the open-drain pins with pull-ups.
`timescale 1ns/1ps
`include "sps_params.svh"
module sps_top_tb;
   logic sys_clk, sys_rst, reg_wr, reg_rd, err_recover, vconn_fault, sink_attached;
   logic fault_req, hub_ocs_req, port_power, ppc_fault_n, overcurrent_sense_n;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [3:0] cfg_strap_level, od_o, od_oe, od_pin;
   sps_pkg::sps_src_t src_status;
   int n_fail = 0;
   int total_checks = 0;
   int cycles = 0;

   sps_top #(.STANDALONE(1'b1), .RECOVER_CYCLES(8)) i_sps_top (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cfg_strap_level(cfg_strap_level), .err_recover(err_recover), .overcurrent_sense_n(overcurrent_sense_n),
      .ppc_fault_n(ppc_fault_n), .vconn_fault(vconn_fault), .sink_attached(sink_attached),
      .src_status(src_status), .port_power(port_power),
      .sink_default_current_n_o(od_o[0]), .sink_default_current_n_oe(od_oe[0]),
      .sink_medium_current_n_o(od_o[1]), .sink_medium_current_n_oe(od_oe[1]),
      .sink_high_current_n_o(od_o[2]), .sink_high_current_n_oe(od_oe[2]),
      .irq_n_o(od_o[3]), .irq_n_oe(od_oe[3]));

   sps_partner i_sps_partner (.port_power(port_power), .fault_req(fault_req), .hub_ocs_req(hub_ocs_req),
      .od_o(od_o), .od_oe(od_oe), .ppc_fault_n(ppc_fault_n), .overcurrent_sense_n(overcurrent_sense_n),
      .od_pin(od_pin));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // ****************************************
   // Access tasks and checks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask

   // Read data are taken at the edge that ends their only valid cycle
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      d = reg_rdata;
      chk(what, exp, d & m);
   endtask

   task automatic wait_pp(input logic v, input int n);
      for (int i = 0; i < n && port_power !== v; i++) @(posedge sys_clk);
      chk("port_power", {31'h0000_0000, v}, {31'h0000_0000, port_power});
   endtask

   task automatic do_reset(input logic [3:0] lvl);
      cfg_strap_level <= lvl;
      sys_rst <= 1'b1;
      cyc(12);
      sys_rst <= 1'b0;
      // Strap capture lands 200 cycles after release
      cyc(210);
   endtask

   function automatic logic [31:0] cfg_exp(input logic [3:0] lvl, input logic [1:0] mode);
      logic [6:0] addr;
      addr = `SPS_SLAVE_ADDR_BASE + {5'h00, lvl[1:0]};
      return {15'h0000, 1'b1, 1'b0, addr, 2'h0, mode, lvl};
   endfunction

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Whole run is near 800 cycles; a hang is cut well past that
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_fail++;
         complete_run();
      end
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      cfg_strap_level = 4'hA;
      err_recover = 1'b1;
      vconn_fault = 1'b0;
      sink_attached = 1'b0;
      fault_req = 1'b0;
      hub_ocs_req = 1'b0;
      src_status = '0;
      @(posedge sys_clk);

      do_reset(4'hA);
      rchk("config_ufp", `SPS_REG_CONFIG, 32'hFFFF_FFFF, cfg_exp(4'hA, 2'h1));
      wr(`SPS_REG_CONFIG, 32'h0000_0000);
      rchk("config_ro", `SPS_REG_CONFIG, 32'hFFFF_FFFF, cfg_exp(4'hA, 2'h1));
      rchk("unmapped", 8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
      for (int c = 0; c < 4; c++) begin
         src_status <= sps_pkg::sps_src_t'{attached: 1'b1, current: 2'(c)};
         cyc(3);
         chk("sink_pins", c < 2 ? 3'b110 : (c == 2 ? 3'b101 : 3'b011), od_pin[2:0]);
      end
      src_status <= sps_pkg::sps_src_t'{attached: 1'b0, current: 2'h3};
      cyc(3);
      chk("sink_pins_detached", 3'b111, od_pin[2:0]);
      chk("irq_masked", 1'b1, od_pin[3]);
      wr(`SPS_REG_MASK, 32'h0000_0008);
      cyc(2);
      chk("irq_pending", 1'b0, od_pin[3]);
      wr(`SPS_REG_STATUS, 32'h0000_0008);
      cyc(2);
      chk("irq_cleared", 1'b1, od_pin[3]);
      $display("test upstream done");

      src_status <= sps_pkg::sps_src_t'{attached: 1'b1, current: 2'h3};
      do_reset(4'hF);
      rchk("config_dfp", `SPS_REG_CONFIG, 32'hFFFF_FFFF, cfg_exp(4'hF, 2'h2));
      chk("sink_pins_dfp", 3'b111, od_pin[2:0]);
      wait_pp(1'b0, 1);
      sink_attached <= 1'b1;
      wait_pp(1'b1, 10);
      fault_req <= 1'b1;
      wait_pp(1'b0, 10);
      fault_req <= 1'b0;
      rchk("state_recover", `SPS_REG_PORT, 32'h0000_0007, 32'h0000_0002);
      rchk("status_fault", `SPS_REG_STATUS, 32'h0000_0002, 32'h0000_0002);
      wait_pp(1'b1, 30);
      err_recover <= 1'b0;
      cyc(5);
      fault_req <= 1'b1;
      wait_pp(1'b0, 10);
      fault_req <= 1'b0;
      cyc(40);
      chk("port_power_locked", 1'b0, port_power);
      rchk("state_locked", `SPS_REG_PORT, 32'h0000_0007, 32'h0000_0006);
      wr(`SPS_REG_CTRL, 32'h0000_0001);
      wait_pp(1'b1, 10);
      vconn_fault <= 1'b1;
      wait_pp(1'b0, 10);
      vconn_fault <= 1'b0;
      rchk("status_vconn", `SPS_REG_STATUS, 32'h0000_0004, 32'h0000_0004);
      wr(`SPS_REG_STATUS, 32'h0000_001F);
      rchk("status_clear", `SPS_REG_STATUS, 32'h0000_001F, 32'h0000_0000);
      wr(`SPS_REG_MASK, 32'h0000_0001);
      hub_ocs_req <= 1'b1;
      cyc(4);
      hub_ocs_req <= 1'b0;
      rchk("status_ocs", `SPS_REG_STATUS, 32'h0000_0001, 32'h0000_0001);
      chk("irq_ocs", 1'b0, od_pin[3]);
      $display("test downstream done");

      do_reset(4'h5);
      rchk("config_comp", `SPS_REG_CONFIG, 32'hFFFF_FFFF, cfg_exp(4'h5, 2'h0));
      wait_pp(1'b0, 4);
      chk("sink_pins_comp", 3'b111, od_pin[2:0]);
      $display("test companion done");
      complete_run();
   end
endmodule

// File: include/sps_params.svh
// Constants for the standalone port signalling block: register offsets,
// field positions, reset values and timing figures.
// Assumes a 200 MHz sys_clk and a byte-addressed register port.
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SPS_ADDR_W 8
`define SPS_REG_STATUS 8'h00
`define SPS_REG_MASK 8'h04
`define SPS_REG_CTRL 8'h08
`define SPS_REG_CONFIG 8'h0C
`define SPS_REG_PORT 8'h10

// ****************************************
// Status and mask bits
// ****************************************
`define SPS_IRQ_W 5
`define SPS_IRQ_OCS 0
`define SPS_IRQ_PWR_FAULT 1
`define SPS_IRQ_VCONN_FAULT 2
`define SPS_IRQ_CFG_DONE 3
`define SPS_IRQ_LOCKED 4
`define SPS_MASK_RESET 5'h00

// ****************************************
// Control and config fields
// ****************************************
`define SPS_CTRL_RESTART 0
`define SPS_CFG_VALUE_LSB 0
`define SPS_CFG_MODE_LSB 4
`define SPS_CFG_ADDR_LSB 8
`define SPS_CFG_VALID 16
`define SPS_SLAVE_ADDR_BASE 7'h20

// ****************************************
// Timing
// ****************************************
`define SPS_CLK_PERIOD_NS 5
`define SPS_STRAP_SETTLE_NS 1000
`define SPS_RECOVER_NS 100000
`define SPS_SETTLE_CNT_W 8
`define SPS_RECOVER_CNT_W 15

`endif

// File: include/sps_pkg.sv
// Types shared by the standalone port signalling block.
// Assumes nothing about its surroundings.
package sps_pkg;

   typedef enum logic [1:0] {
      SPS_MODE_COMPANION = 2'h0,
      SPS_MODE_UFP = 2'h1,
      SPS_MODE_DFP = 2'h2
   } sps_mode_t;

   // Gray along idle, powered, fault, recover
   typedef enum logic [2:0] {
      SPS_CONN_IDLE = 3'h0,
      SPS_CONN_POWERED = 3'h1,
      SPS_CONN_FAULT = 3'h3,
      SPS_CONN_RECOVER = 3'h2,
      SPS_CONN_LOCKED = 3'h6
   } sps_conn_t;

   typedef struct packed {
      logic valid;
      sps_mode_t mode;
      logic [6:0] slave_addr;
      logic [3:0] value;
   } sps_cfg_t;

   typedef struct packed {
      logic attached;
      logic [1:0] current;
   } sps_src_t;

endpackage

// File: src/sps_strap_decode.sv
// Decode of the digitised configuration strap level.
// Assumes the level is already synchronised; purely combinational.
`timescale 1ns/1ps
`include "sps_params.svh"
module sps_strap_decode #(
   parameter bit STANDALONE = 1'b1
) (
   input wire logic [3:0] level,
   output sps_pkg::sps_mode_t mode,
   output logic [6:0] slave_addr
);

   // Top two level bits pick the mode, low two the address offset
   function automatic sps_pkg::sps_mode_t level_mode(input logic [1:0] hi);
      case (hi)
         2'h2: level_mode = sps_pkg::SPS_MODE_UFP;
         2'h3: level_mode = sps_pkg::SPS_MODE_DFP;
         default: level_mode = sps_pkg::SPS_MODE_COMPANION;
      endcase
   endfunction

   assign mode = STANDALONE ? level_mode(level[3:2]) : sps_pkg::SPS_MODE_COMPANION;
   assign slave_addr = `SPS_SLAVE_ADDR_BASE + {5'h00, level[1:0]};

endmodule

// File: src/sps_sync.sv
// Two-stage synchroniser for pin inputs.
// Assumes the inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
module sps_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         meta_reg <= INIT;
         sync_reg <= INIT;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;

endmodule

// File: src/sps_top.sv
// Standalone port signalling: port power control, overcurrent recovery,
// sink current indicators, open-drain interrupt and strap capture.
// Assumes CC detection and fault logic on sys_clk drive src_status,
// sink_attached and vconn_fault; the register port is on sys_clk and all other inputs are pins.
`timescale 1ns/1ps
`include "sps_params.svh"
module sps_top #(
   parameter bit STANDALONE = 1'b1,
   parameter int unsigned RECOVER_CYCLES = `SPS_RECOVER_NS / `SPS_CLK_PERIOD_NS
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [3:0] cfg_strap_level,
   input wire logic err_recover,
   input wire logic overcurrent_sense_n,
   input wire logic ppc_fault_n,
   input wire logic vconn_fault,
   input wire logic sink_attached,
   input wire sps_pkg::sps_src_t src_status,
   output logic port_power,
   output logic sink_default_current_n_o,
   output logic sink_default_current_n_oe,
   output logic sink_medium_current_n_o,
   output logic sink_medium_current_n_oe,
   output logic sink_high_current_n_o,
   output logic sink_high_current_n_oe,
   output logic irq_n_o,
   output logic irq_n_oe
);

   localparam int unsigned SETTLE_CYCLES =
      (`SPS_STRAP_SETTLE_NS + `SPS_CLK_PERIOD_NS - 1) / `SPS_CLK_PERIOD_NS;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [3:0] strap_s;
   logic [2:0] pins_s;
   logic err_rec_s;
   logic ocs_s_n;
   logic ppc_fault_s_n;

   sps_sync #(.W(4), .INIT(4'h0)) u_strap_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .async_in(cfg_strap_level),
      .sync_out(strap_s)
   );

   wire ocs_n_pin_w = overcurrent_sense_n;
   wire ppc_n_pin_w = ppc_fault_n;

   sps_sync #(.W(3), .INIT(3'h6)) u_pin_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .async_in({ocs_n_pin_w, ppc_n_pin_w, err_recover}),
      .sync_out(pins_s)
   );

   assign ocs_s_n = pins_s[2];
   assign ppc_fault_s_n = pins_s[1];
   assign err_rec_s = pins_s[0];

   // ****************************************
   // Strap capture
   // ****************************************
   logic [`SPS_SETTLE_CNT_W-1:0] settle_reg;
   sps_pkg::sps_cfg_t cfg_reg;
   sps_pkg::sps_mode_t dec_mode;
   logic [6:0] dec_addr;
   logic cfg_take;

   sps_strap_decode #(.STANDALONE(STANDALONE)) u_decode (
      .level(strap_s),
      .mode(dec_mode),
      .slave_addr(dec_addr)
   );

   // Wait for the strap divider to settle, then take it once only
   assign cfg_take = !cfg_reg.valid && settle_reg == `SPS_SETTLE_CNT_W'(SETTLE_CYCLES - 1);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         settle_reg <= '0;
         cfg_reg <= '0;
      end else if (cfg_take) begin
         cfg_reg <= '{valid: 1'b1, mode: dec_mode, slave_addr: dec_addr, value: strap_s};
      end else if (!cfg_reg.valid) begin
         settle_reg <= settle_reg + `SPS_SETTLE_CNT_W'(1);
      end
   end

   // Nothing standalone is driven until the strap is known
   wire mode_dfp = cfg_reg.valid && cfg_reg.mode == sps_pkg::SPS_MODE_DFP;
   wire mode_ufp = cfg_reg.valid && cfg_reg.mode == sps_pkg::SPS_MODE_UFP;

   // ****************************************
   // Register port
   // ****************************************
   logic [`SPS_IRQ_W-1:0] status_reg;
   logic [`SPS_IRQ_W-1:0] status_next;
   logic [`SPS_IRQ_W-1:0] mask_reg;
   logic [`SPS_IRQ_W-1:0] irq_set;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic restart_reg;
   sps_pkg::sps_conn_t conn_reg;
   sps_pkg::sps_conn_t conn_next;

   wire sel_status = reg_addr == `SPS_REG_STATUS;
   wire sel_mask = reg_addr == `SPS_REG_MASK;
   wire sel_ctrl = reg_addr == `SPS_REG_CTRL;
   wire sel_config = reg_addr == `SPS_REG_CONFIG;
   wire sel_port = reg_addr == `SPS_REG_PORT;
   // Next mask is shared with the pin so the pin never lags a mask write
   wire [`SPS_IRQ_W-1:0] mask_next = (reg_wr && sel_mask) ? reg_wdata[`SPS_IRQ_W-1:0] : mask_reg;

   wire [31:0] config_word = {15'h0000, cfg_reg.valid, 1'b0, cfg_reg.slave_addr,
      2'h0, cfg_reg.mode, cfg_reg.value};
   wire [31:0] port_word = {22'h00_0000, sink_high_current_n_oe, sink_medium_current_n_oe,
      sink_default_current_n_oe, port_power, err_rec_s, ppc_fault_s_n, ocs_s_n, conn_reg};

   assign rdata_next = !reg_rd ? 32'h0000_0000 :
      sel_status ? {27'h000_0000, status_reg} :
      sel_mask ? {27'h000_0000, mask_reg} :
      sel_config ? config_word :
      sel_port ? port_word : 32'h0000_0000;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdata_reg <= 32'h0000_0000;
         mask_reg <= `SPS_MASK_RESET;
         restart_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         mask_reg <= mask_next;
         restart_reg <= reg_wr && sel_ctrl && reg_wdata[`SPS_CTRL_RESTART];
      end
   end

   assign reg_rdata = rdata_reg;

   // ****************************************
   // Interrupt status
   // ****************************************
   wire fault_now = !ppc_fault_s_n || vconn_fault;

   always_comb begin
      irq_set = '0;
      irq_set[`SPS_IRQ_OCS] = mode_dfp && !ocs_s_n;
      irq_set[`SPS_IRQ_PWR_FAULT] = mode_dfp && !ppc_fault_s_n;
      irq_set[`SPS_IRQ_VCONN_FAULT] = mode_dfp && vconn_fault;
      irq_set[`SPS_IRQ_CFG_DONE] = cfg_take;
      irq_set[`SPS_IRQ_LOCKED] = conn_next == sps_pkg::SPS_CONN_LOCKED &&
         conn_reg != sps_pkg::SPS_CONN_LOCKED;
   end

   // Set beats a write-one clear in the same cycle
   assign status_next = (status_reg & ~((reg_wr && sel_status) ? reg_wdata[`SPS_IRQ_W-1:0] : '0))
      | irq_set;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         status_reg <= '0;
         irq_n_oe <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq_n_oe <= |(status_next & mask_next);
      end
   end

   // ****************************************
   // Connection state machine (downstream)
   // ****************************************
   logic [`SPS_RECOVER_CNT_W-1:0] rec_cnt_reg;
   wire rec_done = rec_cnt_reg == `SPS_RECOVER_CNT_W'(RECOVER_CYCLES - 1);

   always_comb begin
      conn_next = conn_reg;
      case (conn_reg)
         sps_pkg::SPS_CONN_IDLE: begin
            if (mode_dfp && sink_attached) begin
               conn_next = sps_pkg::SPS_CONN_POWERED;
            end
         end
         sps_pkg::SPS_CONN_POWERED: begin
            if (!mode_dfp || !sink_attached) begin
               conn_next = sps_pkg::SPS_CONN_IDLE;
            end else if (fault_now) begin
               conn_next = sps_pkg::SPS_CONN_FAULT;
            end
         end
         sps_pkg::SPS_CONN_FAULT: begin
            conn_next = err_rec_s ? sps_pkg::SPS_CONN_RECOVER : sps_pkg::SPS_CONN_LOCKED;
         end
         sps_pkg::SPS_CONN_RECOVER: begin
            if (!mode_dfp || rec_done) begin
               conn_next = sps_pkg::SPS_CONN_IDLE;
            end
         end
         sps_pkg::SPS_CONN_LOCKED: begin
            // Only software or a mode change releases the lock
            if (!mode_dfp || restart_reg) begin
               conn_next = sps_pkg::SPS_CONN_IDLE;
            end
         end
         default: conn_next = sps_pkg::SPS_CONN_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         conn_reg <= sps_pkg::SPS_CONN_IDLE;
         rec_cnt_reg <= '0;
         port_power <= 1'b0;
      end else begin
         conn_reg <= conn_next;
         rec_cnt_reg <= conn_reg == sps_pkg::SPS_CONN_RECOVER ?
            rec_cnt_reg + `SPS_RECOVER_CNT_W'(1) : '0;
         port_power <= conn_next == sps_pkg::SPS_CONN_POWERED;
      end
   end

   // ****************************************
   // Sink current indicators (upstream)
   // ****************************************
   // none while detached
   wire src_ok = mode_ufp && src_status.attached;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sink_default_current_n_oe <= 1'b0;
         sink_medium_current_n_oe <= 1'b0;
         sink_high_current_n_oe <= 1'b0;
      end else begin
         sink_default_current_n_oe <= src_ok && !src_status.current[1];
         sink_medium_current_n_oe <= src_ok && src_status.current == 2'h2;
         sink_high_current_n_oe <= src_ok && src_status.current == 2'h3;
      end
   end

   // Open-drain pins only ever drive low
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sink_default_current_n_o <= 1'b0;
         sink_medium_current_n_o <= 1'b0;
         sink_high_current_n_o <= 1'b0;
         irq_n_o <= 1'b0;
      end else begin
         sink_default_current_n_o <= 1'b0;
         sink_medium_current_n_o <= 1'b0;
         sink_high_current_n_o <= 1'b0;
         irq_n_o <= 1'b0;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   port_power_on_a: assert property (conn_reg == sps_pkg::SPS_CONN_POWERED |-> port_power && mode_dfp)
      else $error("port power not driven while powered");
   no_auto_rec_a: assert property (conn_reg == sps_pkg::SPS_CONN_FAULT && !err_rec_s
      |=> conn_reg == sps_pkg::SPS_CONN_LOCKED ##1 (restart_reg || !mode_dfp ||
      conn_reg == sps_pkg::SPS_CONN_LOCKED))
      else $error("fault left without recovery strap");
   auto_rec_a: assert property (conn_reg == sps_pkg::SPS_CONN_FAULT && err_rec_s
      |=> conn_reg == sps_pkg::SPS_CONN_RECOVER && !port_power)
      else $error("fault not retried with recovery strap");
   sink_default_a: assert property (src_ok && src_status.current[1] == 1'b0
      |=> sink_default_current_n_oe && !sink_high_current_n_oe)
      else $error("default current indicator missing");
   sink_medium_a: assert property (src_ok && src_status.current == 2'h2 |=> sink_medium_current_n_oe)
      else $error("medium current indicator missing");
   sink_high_a: assert property (src_ok && src_status.current == 2'h3 |=> sink_high_current_n_oe)
      else $error("high current indicator missing");
   irq_pin_a: assert property (irq_n_oe == |(status_reg & mask_reg) && !irq_n_o)
      else $error("interrupt pin disagrees with pending status");
   strap_once_a: assert property (cfg_reg.valid |=> $stable(cfg_reg))
      else $error("strap configuration changed after capture");
   strap_mode_a: assert property (cfg_take |=> cfg_reg.mode == $past(dec_mode) &&
      cfg_reg.slave_addr == $past(dec_addr))
      else $error("captured mode or address wrong");
   strap_value_a: assert property (cfg_take |=> cfg_reg.value == $past(strap_s) &&
      (STANDALONE || cfg_reg.mode == sps_pkg::SPS_MODE_COMPANION))
      else $error("captured strap value wrong");
   ocs_irq_a: assert property (mode_dfp && !ocs_s_n |=> status_reg[`SPS_IRQ_OCS])
      else $error("partner overcurrent not flagged");
   sink_onehot_a: assert property ($onehot0({sink_default_current_n_oe, sink_medium_current_n_oe,
      sink_high_current_n_oe}) && (!$past(src_ok) -> !(sink_default_current_n_oe ||
      sink_medium_current_n_oe || sink_high_current_n_oe)))
      else $error("current indicators overlap or asserted detached");

   cover_locked_c: cover property (conn_reg == sps_pkg::SPS_CONN_LOCKED ##1 restart_reg);
   cover_recover_c: cover property (conn_reg == sps_pkg::SPS_CONN_RECOVER && rec_done);
   cover_high_c: cover property (sink_high_current_n_oe);
   cover_irq_c: cover property (irq_n_oe ##1 !irq_n_oe);

endmodule
